//--- core/sebs_consts.vh
`ifndef SEBS_CONSTS_VH
`define SEBS_CONSTS_VH

// ----------------------------------------------------------------
// Slave address byte layout
// ----------------------------------------------------------------
`define SEBS_RW_BIT        0
`define SEBS_BANK_BIT      1
`define SEBS_STRAP_LO_BIT  2
`define SEBS_STRAP_HI_BIT  3
`define SEBS_TYPE_MSB      7
`define SEBS_TYPE_LSB      4
// Device type identifier, value arbitrary
`define SEBS_DEV_TYPE      4'h5

// ----------------------------------------------------------------
// Array and framing
// ----------------------------------------------------------------
`define SEBS_ADDR_BITS     9
`define SEBS_PAGE_BITS     4
`define SEBS_BYTE_BITS     4'h8
`define SEBS_ACK_LEVEL     1'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEBS_CLK_PERIOD_NS 4
`define SEBS_WR_TIME_NS    5000
`define SEBS_WR_CYCLES     ((`SEBS_WR_TIME_NS + `SEBS_CLK_PERIOD_NS - 1) / `SEBS_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEBS_PIN_IDLE      1'h1
`define SEBS_WP_RESET      1'h1

`endif

//--- core/sebs_sync.v
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Two-stage synchroniser, one chain per bit
// ----------------------------------------------------------------
module sebs_sync #(
  parameter             WIDTH = 5,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b1}}
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar g;

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : chain
      reg meta;
      reg stable;
      // First flop feeds only the second
      always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta   <= INIT[g];
          stable <= INIT[g];
        end else begin
          meta   <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate

endmodule

//--- core/sebs_core.v
`timescale 1ns/100ps
`include "sebs_consts.vh"

// Notes on behaviour
// R1: Read data changes only after SCL falls
// R2: SDA only pulled low or released
// R3: Bus address comes from two strap inputs
// R4: Write protect high blocks all array writes
// R5: START is SDA falling while SCL high
// R6: STOP is SDA rising while SCL high
// R7: Master starts only on an idle bus
// R8: Master keeps SDA stable while SCL high
// R9: Device is slave only, never drives SCL
// R10: Transmitter releases SDA, receiver acks ninth clock
// R11: Acknowledge matching slave address after START
// R12: Acknowledge every byte once selected for write
// R13: Read: release, sample ack, continue if acked
// R14: No ack: stop sending, wait for STOP
// R15: Top four address bits match device type
// R16: Address bits 3 and 2 match straps
// R17: Bank bit is word address bit eight
// R18: Last address bit: 1 read, 0 write
// R19: Word address byte loads low eight bits
// R20: During write cycle ignore START, no ack
// R21: Address counter holds last address plus one
// R22: Sequential read increments all bits, wraps
// R23: Unmatched address: stay released until START

module sebs_core #(
  parameter [3:0]  DEV_TYPE  = `SEBS_DEV_TYPE,  // Arbitrary value
  parameter        ADDR_BITS = `SEBS_ADDR_BITS,
  parameter        PAGE_BITS = `SEBS_PAGE_BITS,
  parameter [15:0] WR_CYCLES = `SEBS_WR_CYCLES
) (
  input  wire clock_i,
  input  wire arst_n_i,
  input  wire scl_i,
  input  wire sda_i,
  output reg  sda_o,
  output reg  sda_oe_o,
  input  wire addr_strap_lo_i,
  input  wire addr_strap_hi_i,
  input  wire write_protect_in_i,
  output reg  busy_o,
  output reg  selected_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RX   = 6'h02;
  localparam [5:0] ST_ACK  = 6'h04;
  localparam [5:0] ST_TX   = 6'h08;
  localparam [5:0] ST_MACK = 6'h10;
  localparam [5:0] ST_WAIT = 6'h20;

  // Kind of byte being received
  localparam [1:0] RX_DEV  = 2'h0;
  localparam [1:0] RX_WORD = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;

  localparam DEPTH = 1 << ADDR_BITS;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [1:0]           rst_pipe;
  wire                 rst_n;
  wire [4:0]           pins_s;
  wire                 scl_s;
  wire                 sda_s;
  wire                 strap_lo_s;
  wire                 strap_hi_s;
  wire                 wp_s;
  reg                  scl_q;
  reg                  sda_q;
  wire                 scl_rise;
  wire                 scl_fall;
  wire                 start_ev;
  wire                 stop_ev;
  reg  [5:0]           state;
  reg  [1:0]           rx_kind;
  reg  [3:0]           bit_cnt;
  reg  [7:0]           rx_sr;
  reg  [7:0]           tx_sr;
  reg                  rd_mode;
  reg                  bank;
  reg                  mack;
  reg                  wrote;
  reg  [ADDR_BITS-1:0] addr;
  reg  [15:0]          wr_cnt;
  reg                  mem_we;
  reg  [ADDR_BITS-1:0] mem_wa;
  reg  [7:0]           mem_wd;
  reg  [7:0]           mem [0:DEPTH-1];
  wire [7:0]           rx_byte;
  wire [7:0]           rd_byte;
  wire                 dev_match;
  wire [PAGE_BITS-1:0] page_next;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------

  // Deassert reset through two flops
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end

  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------

  // All pins are asynchronous to clock_i
  sebs_sync #(
    .WIDTH (5),
    .INIT  ({`SEBS_WP_RESET, 2'h0, `SEBS_PIN_IDLE, `SEBS_PIN_IDLE})
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .async_i ({write_protect_in_i, addr_strap_hi_i, addr_strap_lo_i,
               sda_i, scl_i}),
    .sync_o  (pins_s)
  );

  assign scl_s      = pins_s[0];
  assign sda_s      = pins_s[1];
  assign strap_lo_s = pins_s[2];  // see R3
  assign strap_hi_s = pins_s[3];  // see R3
  assign wp_s       = pins_s[4];

  // Previous sample for edge finding
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= `SEBS_PIN_IDLE;
      sda_q <= `SEBS_PIN_IDLE;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Bus events; SCL is only ever an input, see R9
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;   // see R5
  assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;   // see R6

  // ----------------------------------------------------------------
  // Byte decode
  // ----------------------------------------------------------------

  // Completed byte, last bit is the current shift content
  assign rx_byte = rx_sr;

  // Type identifier and strap compare
  assign dev_match =
    (rx_byte[`SEBS_TYPE_MSB:`SEBS_TYPE_LSB] == DEV_TYPE) &&   // see R15
    (rx_byte[`SEBS_STRAP_HI_BIT] == strap_hi_s) &&            // see R16
    (rx_byte[`SEBS_STRAP_LO_BIT] == strap_lo_s);              // see R16

  // Word at the address counter
  assign rd_byte = mem[addr];

  // Page roll for writes: low bits only
  assign page_next = addr[PAGE_BITS-1:0] + {{(PAGE_BITS-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------

  // Serial state machine, advanced on SCL edges
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      rx_kind    <= RX_DEV;
      bit_cnt    <= 4'h0;
      rx_sr      <= 8'h00;
      tx_sr      <= 8'h00;
      rd_mode    <= 1'h0;
      bank       <= 1'h0;
      mack       <= 1'h0;
      wrote      <= 1'h0;
      addr       <= {ADDR_BITS{1'b0}};
      wr_cnt     <= 16'h0000;
      busy_o     <= 1'h0;
      selected_o <= 1'h0;
      sda_o      <= 1'h0;
      sda_oe_o   <= 1'h0;
      mem_we     <= 1'h0;
      mem_wa     <= {ADDR_BITS{1'b0}};
      mem_wd     <= 8'h00;
    end else begin
      sda_o  <= `SEBS_ACK_LEVEL;  // Open drain: only ever low, see R2
      mem_we <= 1'h0;
      if (busy_o) begin
        // Self-timed write: inputs ignored, no ack
        sda_oe_o <= 1'h0;                                       // see R20
        state    <= ST_IDLE;
        if (wr_cnt == 16'h0000) begin
          busy_o <= 1'h0;
        end else begin
          wr_cnt <= wr_cnt - 16'h0001;
        end
      end else if (stop_ev) begin
        // STOP ends any transfer and starts the write cycle if a byte was written
        state      <= ST_IDLE;
        sda_oe_o   <= 1'h0;
        selected_o <= 1'h0;
        if (wrote) begin
          wrote  <= 1'h0;
          busy_o <= 1'h1;
          wr_cnt <= WR_CYCLES - 16'h0001;
        end
      end else if (start_ev) begin
        // START or repeated START: receive slave address
        state      <= ST_RX;
        rx_kind    <= RX_DEV;
        bit_cnt    <= 4'h0;
        sda_oe_o   <= 1'h0;
        selected_o <= 1'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe_o <= 1'h0;
          end
          ST_RX: begin
            if (scl_rise) begin
              rx_sr   <= {rx_sr[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `SEBS_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              case (rx_kind)
                RX_DEV: begin
                  if (dev_match) begin
                    state      <= ST_ACK;
                    sda_oe_o   <= 1'h1;                       // see R11
                    selected_o <= 1'h1;
                    bank       <= rx_byte[`SEBS_BANK_BIT];    // see R17
                    rd_mode    <= rx_byte[`SEBS_RW_BIT];      // see R18
                    if (rx_byte[`SEBS_RW_BIT]) begin
                      // Bank bit steers address bit eight
                      addr[ADDR_BITS-1] <= rx_byte[`SEBS_BANK_BIT];  // see R17
                    end
                  end else begin
                    state <= ST_WAIT;                         // see R23
                  end
                end
                RX_WORD: begin
                  addr     <= {bank, rx_byte};                // see R19
                  state    <= ST_ACK;
                  sda_oe_o <= 1'h1;                           // see R12
                end
                default: begin
                  if (!wp_s) begin
                    mem_we <= 1'h1;                           // see R4
                    mem_wa <= addr;
                    mem_wd <= rx_byte;
                    wrote  <= 1'h1;
                  end
                  addr[PAGE_BITS-1:0] <= page_next;           // see R21
                  state    <= ST_ACK;
                  sda_oe_o <= 1'h1;                           // see R12
                end
              endcase
            end
          end
          ST_ACK: begin
            // Ack held low through the ninth clock
            if (scl_fall) begin
              if (rd_mode) begin
                // First bit appears right after the fall
                state    <= ST_TX;
                tx_sr    <= rd_byte;
                sda_oe_o <= ~rd_byte[7];                      // see R1
                addr     <= addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};  // see R21
              end else begin
                state    <= ST_RX;
                sda_oe_o <= 1'h0;                             // see R10
                rx_kind  <= (rx_kind == RX_DEV) ? RX_WORD : RX_DATA;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == `SEBS_BYTE_BITS) begin
                // Byte done: release for master ack
                state    <= ST_MACK;
                bit_cnt  <= 4'h0;
                sda_oe_o <= 1'h0;                             // see R13
              end else begin
                tx_sr    <= {tx_sr[6:0], 1'h0};
                sda_oe_o <= ~tx_sr[6];                        // see R1
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack <= (sda_s == `SEBS_ACK_LEVEL);             // see R13
            end else if (scl_fall) begin
              if (mack) begin
                // Next word, full-width wrap
                state    <= ST_TX;
                tx_sr    <= rd_byte;
                sda_oe_o <= ~rd_byte[7];                      // see R13
                addr     <= addr + {{(ADDR_BITS-1){1'b0}}, 1'b1};  // see R22
              end else begin
                state    <= ST_WAIT;                          // see R14
                sda_oe_o <= 1'h0;
              end
            end
          end
          ST_WAIT: begin
            // Released until STOP or a new START
            sda_oe_o <= 1'h0;                                 // see R14
          end
          default: begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'h0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------

  // Write port, fed by the engine
  always @(posedge clock_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

endmodule

//--- testbench/sebs_core_asserts.sv
`timescale 1ns/100ps

// --------------------------------
// Checker on the core pins
// --------------------------------
module sebs_core_asserts #(
  parameter [15:0] WR_CYCLES = 16'd20
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire addr_strap_lo_i,
  input wire addr_strap_hi_i,
  input wire write_protect_in_i,
  input wire busy_o,
  input wire selected_o
);
  reg [15:0] busy_cnt;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // Bus conditions on the pins
  sequence stop_seen;
    scl_i && $rose(sda_i);
  endsequence
  sequence start_seen;
    scl_i && $fell(sda_i);
  endsequence

  // Length of the write cycle
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= busy_o ? busy_cnt + 16'h0001 : 16'h0000;
  end

  open_drain_a: assert property (sda_o == 1'b0)
    else $error("sda drive value not low");
  oe_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 3))
    else $error("sda changed while scl high");
  oe_stand_a: assert property ($changed(sda_oe_o) |=> $stable(sda_oe_o) [*7])
    else $error("sda bit too short");
  busy_quiet_a: assert property (busy_o |-> !sda_oe_o && !selected_o)
    else $error("answer during write cycle");
  busy_len_a: assert property ($fell(busy_o) |-> busy_cnt == WR_CYCLES)
    else $error("write cycle length wrong");
  busy_cause_a: assert property ($rose(busy_o) |-> scl_i && sda_i && !write_protect_in_i)
    else $error("write cycle without stop or while protected");
  stop_clears_a: assert property (stop_seen |-> ##[1:5] !selected_o)
    else $error("stop did not deselect");
  start_clears_a: assert property (start_seen |-> ##[1:5] !selected_o)
    else $error("start did not deselect");
endmodule

bind sebs_core sebs_core_asserts #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_strap_lo_i(addr_strap_lo_i),
  .addr_strap_hi_i(addr_strap_hi_i), .write_protect_in_i(write_protect_in_i),
  .busy_o(busy_o), .selected_o(selected_o));

//--- testbench/sebs_master_model.sv
`timescale 1ns/100ps

// --------------------------------
// Bus master, 64 ns serial clock
// --------------------------------
module sebs_master_model (
  input  wire clock_i,
  input  wire sda_i,
  output reg  scl_o,
  output reg  sdl_o
);
  integer i;

  initial begin
    scl_o = 1'b1;
    sdl_o = 1'b1;
  end

  // One clock phase
  task half;
    repeat (8) @(posedge clock_i);
  endtask

  // Start from a released bus
  task start;
    begin
      sdl_o <= 1'b1; half;
      scl_o <= 1'b1; half;
      sdl_o <= 1'b0; half;
      scl_o <= 1'b0; half;
    end
  endtask

  // Stop, bus left idle
  task stop;
    begin
      sdl_o <= 1'b0; half;
      scl_o <= 1'b1; half;
      sdl_o <= 1'b1; half;
    end
  endtask

  // Eight bits out, ninth bit given as a
  task xbyte(input [7:0] d, input a, output [7:0] q, output k);
    reg [8:0] s;
    begin
      s = {d, a};
      for (i = 8; i >= 0; i = i - 1) begin
        sdl_o <= s[i]; half;
        scl_o <= 1'b1; half;
        if (i > 0) q[i-1] = sda_i;
        else k = sda_i;
        scl_o <= 1'b0;
      end
    end
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
`include "sebs_consts.vh"

module tb;
  reg         clock_i  = 1'b0;
  reg         arst_n_i = 1'b0;
  reg         s_lo     = 1'b0;
  reg         s_hi     = 1'b1;
  reg         wp       = 1'b0;
  reg  [7:0]  r;
  reg  [7:0]  d;
  reg         k;
  wire        scl, sdl, sda, oe, drv, busy, sel;
  integer     bad_count = 0;
  integer     checked   = 0;
  integer     cycles    = 0;

`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin bad_count = bad_count + 1; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end

  initial forever #2 clock_i = ~clock_i;
  // Open-drain wire with pull-up
  assign sda = sdl & (~oe | drv);

  sebs_core #(.WR_CYCLES(16'd400)) dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(drv), .sda_oe_o(oe), .addr_strap_lo_i(s_lo), .addr_strap_hi_i(s_hi),
    .write_protect_in_i(wp), .busy_o(busy), .selected_o(sel));
  sebs_master_model m (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sdl_o(sdl));

  function [7:0] ab(input b, input rw);
    ab = {`SEBS_DEV_TYPE, s_hi, s_lo, b, rw};
  endfunction

  // One byte from the master, ack checked
  task send(input [7:0] v, input e);
    begin
      m.xbyte(v, 1'b1, r, k);
      `CHK(k, e)
    end
  endtask

  // Byte write
  task wr(input b, input [7:0] w, input [7:0] v);
    begin
      m.start;
      send(ab(b, 1'b0), `SEBS_ACK_LEVEL);
      `CHK(sel, 1'b1)
      send(w, `SEBS_ACK_LEVEL);
      send(v, `SEBS_ACK_LEVEL);
      m.stop;
    end
  endtask

  // Random read, a is the master's ninth bit
  task rd(input b, input [7:0] w, input a, output [7:0] q);
    begin
      m.start;
      send(ab(b, 1'b0), `SEBS_ACK_LEVEL);
      send(w, `SEBS_ACK_LEVEL);
      m.start;
      send(ab(b, 1'b1), `SEBS_ACK_LEVEL);
      m.xbyte(8'hff, a, q, k);
    end
  endtask

  // Bounded wait for write cycle end
  task wait_idle;
    integer n;
    begin
      for (n = 0; n < 600 && busy !== 1'b0; n = n + 1) @(posedge clock_i);
      `CHK(busy, 1'b0)
    end
  endtask

  task give_verdict;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // Run limit
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    wr(1'b1, 8'h10, 8'h3c);
    `CHK(busy, 1'b1)
    m.start;
    send(ab(1'b1, 1'b0), 1'b1);
    m.stop;
    wait_idle;
    rd(1'b1, 8'h10, 1'b1, d);
    `CHK(d, 8'h3c)
    m.stop;
    `CHK(sel, 1'b0)
    wp <= 1'b1;
    wr(1'b1, 8'h10, 8'ha5);
    `CHK(busy, 1'b0)
    rd(1'b1, 8'h10, 1'b1, d);
    `CHK(d, 8'h3c)
    m.stop;
    wp <= 1'b0;
    m.start;
    send(ab(1'b0, 1'b0) ^ 8'h04, 1'b1);
    `CHK(sel, 1'b0)
    send(8'h00, 1'b1);
    m.start;
    send(ab(1'b0, 1'b0) ^ 8'h80, 1'b1);
    m.stop;
    s_hi <= 1'b0;
    s_lo <= 1'b1;
    wr(1'b1, 8'hff, 8'h77);
    wait_idle;
    wr(1'b0, 8'h00, 8'h88);
    wait_idle;
    wr(1'b0, 8'h01, 8'h99);
    wait_idle;
    rd(1'b1, 8'hff, 1'b0, d);
    `CHK(d, 8'h77)
    m.xbyte(8'hff, 1'b1, d, k);
    `CHK(d, 8'h88)
    m.stop;
    // Current-address read picks up after the last word read
    m.start;
    send(ab(1'b0, 1'b1), `SEBS_ACK_LEVEL);
    m.xbyte(8'hff, 1'b1, d, k);
    `CHK(d, 8'h99)
    m.stop;
    give_verdict;
  end
endmodule
